/* File: ipvu_core.v */
`timescale 1ns/10ps
`include "ipvu_consts.vh"
// Operation
// - fixed non-maskable rank, reset first
// - nmi pin honoured only when pin-mask clear
// - maskable requests need global mask clear
// - global mask resets to one, always writable
// - one maskable source promoted to top
// - promoted source still masked and enabled
// - vector fixed regardless of promotion
// - promotion register written only while masked
// - reset-class vectors fffe, fffc, fffa
// - trap, swtrap, nmi at fff8, fff6, fff4
// - maskable slots descend; code equals vector low byte
// - default maskable order per table
// - each serial channel shares one vector
// - can error ors six enabled conditions
// - lock and limp-home share lowest vector
// - pulse acc overflow/edge below timer overflow
module ipvu_core (
  input wire clk_sys_i,
  input wire srst_i,
  // reset-class and trap sources, same clock domain
  input wire por_reset_i,
  input wire clkmon_reset_i,
  input wire watchdog_reset_source_i,
  input wire unimpl_trap_i,
  input wire software_trap_instr_i,
  // external pins, asynchronous
  input wire nonmaskable_irq_pin_n_i,
  input wire ext_irq_n_i,
  // condition code bits written by the core
  input wire ccr_wr_i,
  input wire ccr_x_i,
  input wire ccr_i_i,
  // promotion register write port
  input wire prio_wr_i,
  input wire [7:0] prio_wdata_i,
  // simple maskable requests with their enables (index order of default ranking)
  input wire ext_irq_en_i,
  input wire [22:0] simple_req_i,
  input wire [22:0] simple_en_i,
  // shared-vector sources
  input wire pa_ovf_i,
  input wire pulse_acc_ovf_irq_en_i,
  input wire pa_edge_i,
  input wire pulse_acc_edge_irq_en_i,
  input wire [3:0] ser0_flags_i,
  input wire [3:0] serial0_control_two_i,
  input wire [3:0] ser1_flags_i,
  input wire [3:0] serial1_control_two_i,
  input wire [5:0] can_err_flags_i,
  input wire [5:0] can_err_en_i,
  input wire lock_evt_i,
  input wire lock_irq_en_i,
  input wire limp_evt_i,
  input wire limp_home_irq_en_i,
  // vector fetch by the core
  input wire vec_rd_i,
  input wire vec_odd_i,
  output reg [7:0] vec_byte_o,
  output reg [15:0] vec_addr_o,
  output reg irq_pending_o,
  output reg vec_nonmaskable_o,
  output wire ccr_x_o,
  output wire ccr_i_o,
  output wire [7:0] priority_raise_select_o
);
  reg x_q;
  reg i_q;
  reg [7:0] prio_q;
  reg [2:0] nmi_sync_q;
  reg [2:0] irq_sync_q;
  reg nmi_lvl_q;
  reg irq_lvl_q;
  reg [15:0] vec_d;
  reg pend_d;
  reg nm_d;
  reg [4:0] sel_idx;
  reg sel_hit;
  reg [4:0] top_idx;
  reg top_ok;
  reg [8:0] code_diff;
  integer k;
  wire [24:0] mreq;
  wire [24:0] gated;
  wire [15:0] sel_vec;
  wire [15:0] top_vec;
  wire [7:0] sel_code;
  wire [7:0] top_code;

  // condition code mask bits: set out of reset, writable any time
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      x_q <= 1'b1;
      i_q <= 1'b1;
    end else if (ccr_wr_i) begin
      x_q <= ccr_x_i;
      i_q <= ccr_i_i;
    end
  end
  assign ccr_x_o = x_q;
  assign ccr_i_o = i_q;

  // promotion register; a write while unmasked is dropped to avoid reordering mid-service
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      prio_q <= `IPVU_PRIO_RESET;
    end else if (prio_wr_i && i_q) begin
      prio_q <= prio_wdata_i;
    end
  end
  assign priority_raise_select_o = prio_q;

  // three-stage pin synchronisers; a change counts once stages two and three agree
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      nmi_sync_q <= 3'h7;
      irq_sync_q <= 3'h7;
      nmi_lvl_q <= 1'b0;
      irq_lvl_q <= 1'b0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], nonmaskable_irq_pin_n_i};
      irq_sync_q <= {irq_sync_q[1:0], ext_irq_n_i};
      if (nmi_sync_q[1] == nmi_sync_q[2]) begin
        nmi_lvl_q <= ~nmi_sync_q[2];
      end
      if (irq_sync_q[1] == irq_sync_q[2]) begin
        irq_lvl_q <= ~irq_sync_q[2];
      end
    end
  end

  // maskable request vector in default order, index 0 highest
  assign mreq[0] = irq_lvl_q & ext_irq_en_i;
  // periodic tick, timer channels 0 to 7 and timer overflow take slots 1 to 10
  assign mreq[10:1] = simple_req_i[9:0] & simple_en_i[9:0];
  assign mreq[`IPVU_SRC_PA_OVF] = pa_ovf_i & pulse_acc_ovf_irq_en_i;
  assign mreq[`IPVU_SRC_PA_EDGE] = pa_edge_i & pulse_acc_edge_irq_en_i;
  assign mreq[`IPVU_SRC_SER0 - 1] = simple_req_i[10] & simple_en_i[10];
  assign mreq[`IPVU_SRC_SER0] = |(ser0_flags_i & serial0_control_two_i);
  assign mreq[`IPVU_SRC_SER1] = |(ser1_flags_i & serial1_control_two_i);
  // converters, can wake, key wake, modulus, second accumulator; bits 18 to 22 are spare
  assign mreq[20:16] = simple_req_i[15:11] & simple_en_i[15:11];
  assign mreq[`IPVU_SRC_CANERR] = |(can_err_flags_i & can_err_en_i);
  assign mreq[23:22] = simple_req_i[17:16] & simple_en_i[17:16];
  assign mreq[`IPVU_SRC_LOCK] = (lock_evt_i & lock_irq_en_i) | (limp_evt_i & limp_home_irq_en_i);

  // local enables already applied above; global mask blocks all, promoted or not
  assign gated = i_q ? {25{1'b0}} : mreq;

  // promoted slot index derived from the register value
  always @* begin
    top_idx = 5'h00;
    top_ok = 1'b0;
    code_diff = {1'b0, `IPVU_PRIO_RESET} - {1'b0, prio_q};
    // code must lie in range and be even to name a real source
    if (prio_q <= `IPVU_PRIO_RESET && prio_q >= `IPVU_PRIO_LOW && !prio_q[0]) begin
      top_idx = code_diff[5:1];
      top_ok = 1'b1;
    end
  end

  // fixed-order scan, then promoted source overrides if it is requesting
  always @* begin
    sel_idx = 5'h00;
    sel_hit = 1'b0;
    for (k = `IPVU_NUM_MASKABLE - 1; k >= 0; k = k - 1) begin
      if (gated[k]) begin
        sel_idx = k[4:0];
        sel_hit = 1'b1;
      end
    end
    if (top_ok && gated[top_idx]) begin
      sel_idx = top_idx;
      sel_hit = 1'b1;
    end
  end

  ipvu_vec_rom u_rom (
    .idx_i(sel_idx),
    .vec_o(sel_vec),
    .prio_code_o(sel_code)
  );
  ipvu_vec_rom u_rom_top (
    .idx_i(top_idx),
    .vec_o(top_vec),
    .prio_code_o(top_code)
  );

  // non-maskable ranking ahead of maskable selection
  always @* begin
    pend_d = 1'b1;
    nm_d = 1'b1;
    if (por_reset_i) begin
      vec_d = `IPVU_VEC_RESET;
    end else if (clkmon_reset_i) begin
      vec_d = `IPVU_VEC_CLKMON;
    end else if (watchdog_reset_source_i) begin
      vec_d = `IPVU_VEC_WDOG;
    end else if (unimpl_trap_i) begin
      vec_d = `IPVU_VEC_TRAP;
    end else if (software_trap_instr_i) begin
      vec_d = `IPVU_VEC_SWTRAP;
    end else if (nmi_lvl_q && !x_q) begin
      vec_d = `IPVU_VEC_NMI;
    end else begin
      nm_d = 1'b0;
      pend_d = sel_hit;
      vec_d = sel_hit ? sel_vec : 16'h0000;
    end
  end

  // registered vector and byte fetch: even address gives high byte
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      vec_addr_o <= 16'h0000;
      irq_pending_o <= 1'b0;
      vec_nonmaskable_o <= 1'b0;
      vec_byte_o <= 8'h00;
    end else begin
      vec_addr_o <= vec_d;
      irq_pending_o <= pend_d;
      vec_nonmaskable_o <= nm_d;
      if (vec_rd_i) begin
        vec_byte_o <= vec_odd_i ? vec_addr_o[7:0] : vec_addr_o[15:8];
      end
    end
  end
endmodule

/* File: ipvu_consts.vh */
`ifndef IPVU_CONSTS_VH
`define IPVU_CONSTS_VH
// non-maskable vectors
`define IPVU_VEC_RESET 16'hfffe
`define IPVU_VEC_CLKMON 16'hfffc
`define IPVU_VEC_WDOG 16'hfffa
`define IPVU_VEC_TRAP 16'hfff8
`define IPVU_VEC_SWTRAP 16'hfff6
`define IPVU_VEC_NMI 16'hfff4
// maskable slots descend two bytes from the external request
`define IPVU_VEC_MASK_TOP 16'hfff2
`define IPVU_NUM_MASKABLE 25
`define IPVU_PRIO_RESET 8'hf2
`define IPVU_PRIO_LOW 8'hc2
// source indices inside the maskable request vector
`define IPVU_SRC_PA_OVF 11
`define IPVU_SRC_PA_EDGE 12
`define IPVU_SRC_SER0 14
`define IPVU_SRC_SER1 15
`define IPVU_SRC_CANERR 21
`define IPVU_SRC_LOCK 24
`endif

/* File: ipvu_vec_rom.v */
`timescale 1ns/10ps
`include "ipvu_consts.vh"
// maps a maskable source index to its fixed vector; vector never depends on priority
module ipvu_vec_rom (
  input wire [4:0] idx_i,
  output wire [15:0] vec_o,
  output wire [7:0] prio_code_o
);
  // slot n sits 2*n bytes below the top maskable vector
  assign vec_o = `IPVU_VEC_MASK_TOP - {10'h000, idx_i, 1'b0};
  assign prio_code_o = vec_o[7:0];
endmodule

/* File: ipvu_monitor.sv */
`timescale 1ns/10ps
module ipvu_monitor (
  input wire clk_sys_i,
  input wire srst_i,
  input wire por_reset_i,
  input wire ccr_wr_i,
  input wire ccr_i_i,
  input wire prio_wr_i,
  input wire [7:0] prio_wdata_i,
  input wire vec_rd_i,
  input wire vec_odd_i,
  input wire [7:0] vec_byte_o,
  input wire [15:0] vec_addr_o,
  input wire vec_nonmaskable_o,
  input wire ccr_x_o,
  input wire ccr_i_o,
  input wire [7:0] priority_raise_select_o
);
  reg [15:0] addr_q;
  // slot that a byte read was aimed at
  always @(posedge clk_sys_i) begin
    addr_q <= vec_addr_o;
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  // masks come up set so no nmi pin or maskable request is taken before software is ready
  mask_reset_a: assert property ($past(srst_i) |-> ccr_i_o && ccr_x_o)
    else $error("masks not set after reset");
  mask_load_a: assert property (ccr_wr_i |=> ccr_i_o == $past(ccr_i_i))
    else $error("global mask not loaded");
  prio_hold_a: assert property (!(prio_wr_i && ccr_i_o) |=> $stable(priority_raise_select_o))
    else $error("promotion changed without a masked write");
  prio_take_a: assert property (prio_wr_i && ccr_i_o && !prio_wdata_i[0] && prio_wdata_i > 8'hc1
    && prio_wdata_i < 8'hf3 |=> priority_raise_select_o == $past(prio_wdata_i))
    else $error("promotion write lost");
  reset_vec_a: assert property (por_reset_i |=> vec_addr_o == 16'hfffe && vec_nonmaskable_o)
    else $error("reset vector not chosen");
  byte_hi_a: assert property (vec_rd_i && !vec_odd_i |=> vec_byte_o == addr_q[15:8])
    else $error("even fetch gave wrong byte");
  byte_lo_a: assert property (vec_rd_i && vec_odd_i |=> vec_byte_o == addr_q[7:0])
    else $error("odd fetch gave wrong byte");
  byte_hold_a: assert property (!vec_rd_i |=> $stable(vec_byte_o))
    else $error("fetched byte moved without a read");
endmodule
bind ipvu_core ipvu_monitor ipvu_monitor_i (.*);

/* File: ipvu_fetch_model.sv */
`timescale 1ns/10ps
module ipvu_fetch_model (
  input wire clk_sys_i,
  input wire go_i,
  input wire [7:0] vec_byte_i,
  output reg vec_rd_o,
  output reg vec_odd_o,
  output reg [15:0] word_o,
  output reg done_o
);
  reg [1:0] step_q;
  initial begin
    {step_q, vec_rd_o, vec_odd_o, word_o, done_o} = 21'h0;
  end
  // core fetch: even byte then odd byte, each answered one cycle later
  always @(posedge clk_sys_i) begin
    vec_rd_o <= go_i || step_q == 2'h1;
    vec_odd_o <= step_q == 2'h1;
    step_q <= go_i ? 2'h1 : step_q + {1'b0, step_q != 2'h0};
    done_o <= step_q == 2'h3;
    if (step_q == 2'h2) word_o[15:8] <= vec_byte_i;
    if (step_q == 2'h3) word_o[7:0] <= vec_byte_i;
  end
endmodule

/* File: interrupt_priority_vector_unit_bench.sv */
`timescale 1ns/10ps
module interrupt_priority_vector_unit_bench;
  reg clk_sys_i, srst_i, ccr_wr_i, ccr_x_i, ccr_i_i, prio_wr_i, go, x, i;
  reg [7:0] prio_wdata_i, p;
  reg [25:0] rq, en;
  reg [15:0] e;
  integer seed, fail_count, total_checks, n, k;
  wire vec_rd_i, vec_odd_i, irq_pending_o, vec_nonmaskable_o, ccr_x_o, ccr_i_o, done;
  wire por_reset_i, clkmon_reset_i, watchdog_reset_source_i, unimpl_trap_i, software_trap_instr_i;
  wire nonmaskable_irq_pin_n_i, ext_irq_n_i, ext_irq_en_i, pa_ovf_i, pa_edge_i, lock_evt_i, limp_evt_i;
  wire pulse_acc_ovf_irq_en_i, pulse_acc_edge_irq_en_i, lock_irq_en_i, limp_home_irq_en_i;
  wire [3:0] ser0_flags_i, ser1_flags_i, serial0_control_two_i, serial1_control_two_i;
  wire [5:0] can_err_flags_i, can_err_en_i;
  wire [22:0] simple_req_i, simple_en_i;
  wire [7:0] vec_byte_o, priority_raise_select_o;
  wire [15:0] vec_addr_o, word;
  // bit k of rq is source k in falling priority; pins are active low
  assign {software_trap_instr_i, unimpl_trap_i, watchdog_reset_source_i, clkmon_reset_i, por_reset_i} = rq[4:0];
  assign nonmaskable_irq_pin_n_i = !rq[5];
  assign ext_irq_n_i = !rq[6];
  assign simple_req_i = {22'h0, rq[7]};
  assign {limp_evt_i, lock_evt_i, can_err_flags_i, ser1_flags_i, ser0_flags_i, pa_edge_i, pa_ovf_i} = rq[25:8];
  assign ext_irq_en_i = en[6];
  assign simple_en_i = {22'h0, en[7]};
  assign {limp_home_irq_en_i, lock_irq_en_i, can_err_en_i, serial1_control_two_i, serial0_control_two_i,
    pulse_acc_edge_irq_en_i, pulse_acc_ovf_irq_en_i} = en[25:8];
  ipvu_core ipvu_core_i (.*);
  ipvu_fetch_model ipvu_fetch_model_i (.clk_sys_i(clk_sys_i), .go_i(go), .vec_byte_i(vec_byte_o),
    .vec_rd_o(vec_rd_i), .vec_odd_o(vec_odd_i), .word_o(word), .done_o(done));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // fixed slot of source k, independent of promotion
  function [15:0] vexp(input integer k);
    vexp = k < 7 ? 16'hfffe - 2 * k : k == 7 ? 16'hfff0 : k < 10 ? 16'hffdc - 2 * (k - 8) :
      k < 14 ? 16'hffd6 : k < 18 ? 16'hffd4 : k < 24 ? 16'hffc8 : 16'hffc2;
  endfunction
  // winner among live requests; promotion only among maskable ones
  function [15:0] best(input [25:0] r, input [7:0] c);
    integer j;
    begin
      best = 16'h0000;
      for (j = 25; j >= 0; j = j - 1)
        if (r[j]) best = vexp(j);
      if (r[5:0] == 6'h0)
        for (j = 6; j < 26; j = j + 1)
          if (r[j] && vexp(j) == {8'hff, c}) best = vexp(j);
    end
  endfunction
  task check(input [15:0] s, input [15:0] w);
    begin
      total_checks = total_checks + 1;
      if (s !== w) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, s, w);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // condition code load with an optional promotion write on the same edge
  task wr(input cx, input ci, input pw, input [7:0] pd);
    begin
      @(posedge clk_sys_i);
      {ccr_wr_i, ccr_x_i, ccr_i_i, prio_wr_i, prio_wdata_i} <= {1'b1, cx, ci, pw, pd};
      @(posedge clk_sys_i);
      {ccr_wr_i, prio_wr_i} <= 2'b00;
    end
  endtask
  task fetch(input [15:0] v);
    integer t;
    begin
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      for (t = 0; t < 8 && done !== 1'b1; t = t + 1)
        @(posedge clk_sys_i);
      if (t == 8) fail_count = fail_count + 1;
      if (t == 8) finish_test;
      check(word, v);
    end
  endtask
  initial begin
    seed = 30751;
    fail_count = 0;
    total_checks = 0;
    srst_i = 1'b1;
    {ccr_wr_i, ccr_x_i, ccr_i_i, prio_wr_i, go, prio_wdata_i, rq, en} = 65'h0;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    check({6'h0, ccr_x_o, ccr_i_o, priority_raise_select_o}, 16'h03f2);
    // first 26 rounds walk each source alone, then random mixes
    for (n = 0; n < 326; n = n + 1) begin
      k = {$random(seed)} % 26;
      p = k == 25 ? 8'he1 : 8'hc2 + 2 * k;
      x = n > 25 && $random(seed) % 2;
      i = n > 25 && $random(seed) % 2;
      // software masks before it changes the promoted source
      wr(x, 1'b1, 1'b0, 8'h00);
      wr(x, i, 1'b1, p);
      wr(x, i, 1'b1, 8'hd8);
      if (i) p = 8'hd8;
      // look between edges so the register has settled
      @(negedge clk_sys_i);
      if (!p[0]) check({8'h0, priority_raise_select_o}, {8'h0, p});
      @(posedge clk_sys_i);
      rq <= n < 26 ? 26'h1 << n : $random(seed) & $random(seed) & $random(seed) &
        ($random(seed) % 4 ? 26'h3ffffc0 : 26'h3ffffff);
      en <= n < 26 ? 26'h3ffffff : $random(seed) | $random(seed);
      repeat (6) @(posedge clk_sys_i);
      e = best(rq & (en | 26'h3f) & {{20{!i}}, !x, 5'h1f}, p);
      check(vec_addr_o, e);
      check({14'h0, irq_pending_o, vec_nonmaskable_o}, {14'h0, e != 16'h0, e > 16'hfff3});
      fetch(e);
    end
    finish_test;
  end
endmodule
